// ---- design/cdhp_pkg.sv ----
package cdhp_pkg;

    // ****************************************
    // Memory sizes and address layout
    // ****************************************
    localparam int         DISPLAY_DATA_RAM_DEPTH   = 80;
    localparam int         GLYPH_RAM_DEPTH   = 64;
    localparam logic [6:0] LINE_LEN      = 7'h28;
    localparam logic [6:0] LINE2_BASE    = 7'h40;
    localparam logic [6:0] LINE1_LAST    = 7'h27;
    localparam logic [6:0] LINE2_LAST    = 7'h67;
    localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
    localparam logic [7:0] BLANK_CODE    = 8'h20;

    // ****************************************
    // Strap coding and instruction fields
    // ****************************************
    localparam logic [1:0] STRAP_PARALLEL = 2'h3;
    localparam int CMD_DDADDR_BIT = 7;
    localparam int CMD_CGADDR_BIT = 6;
    localparam int CMD_FUNC_BIT   = 5;
    localparam int CMD_SHIFT_BIT  = 4;
    localparam int CMD_DISP_BIT   = 3;
    localparam int CMD_ENTRY_BIT  = 2;
    localparam int CMD_HOME_BIT   = 1;
    localparam int CMD_CLEAR_BIT  = 0;
    localparam int FUNC_DL_BIT    = 4;
    localparam int FUNC_N_BIT     = 3;
    localparam int SHIFT_SC_BIT   = 3;
    localparam int SHIFT_RL_BIT   = 2;
    localparam int DISP_D_BIT     = 2;
    localparam int ENTRY_ID_BIT   = 1;
    localparam int ENTRY_S_BIT    = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_BUS_WIDE = 1'b1;
    localparam logic RST_TWO_LINE = 1'b0;
    localparam logic RST_INCR     = 1'b1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ      = 25;
    localparam int SHORT_OP_NS  = 18500;
    localparam int LONG_OP_NS   = 760000;
    localparam int SHORT_OP_CYC = (SHORT_OP_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_OP_CYC  = (LONG_OP_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WRITE, ST_FETCH, ST_LOAD, ST_CLEAR, ST_WAIT
    } cdhp_state_t;

    // ****************************************
    // Address arithmetic
    // ****************************************
    function automatic logic [6:0] display_data_ram_index(input logic [6:0] a,
                                               input logic       two);
        if (two && a >= LINE2_BASE)
            return 7'(a - LINE2_BASE + LINE_LEN);
        return a;
    endfunction : display_data_ram_index

    function automatic logic [6:0] ac_step(input logic [6:0] a,
                                           input logic up,
                                           input logic two,
                                           input logic cg);
        logic [6:0] s;
        s = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
        if (cg) begin
            s = {1'b0, s[5:0]};
        end else if (two) begin
            if (up && a == LINE1_LAST) s = LINE2_BASE;
            else if (up && a == LINE2_LAST) s = 7'h00;
            else if (!up && a == LINE2_BASE) s = LINE1_LAST;
            else if (!up && a == 7'h00) s = LINE2_LAST;
        end else begin
            if (up && a == ONE_LINE_LAST) s = 7'h00;
            else if (!up && a == 7'h00) s = ONE_LINE_LAST;
        end
        return s;
    endfunction : ac_step

    function automatic logic [6:0] shift_step(input logic [6:0] off,
                                              input logic left,
                                              input logic two);
        logic [6:0] lim;
        lim = two ? 7'(LINE_LEN - 7'h01) : ONE_LINE_LAST;
        if (left)
            return (off >= lim) ? 7'h00 : 7'(off + 7'h01);
        return (off == 7'h00) ? lim : 7'(off - 7'h01);
    endfunction : shift_step

endpackage : cdhp_pkg

// ---- design/cdhp_mem_if.sv ----
`timescale 1ns/1ns
interface cdhp_mem_if #(parameter int AW = 7, parameter int DW = 8);
    logic          wrEn;
    logic [AW-1:0] addr;
    logic [DW-1:0] wrData;
    logic [DW-1:0] rdData;
    modport ctrl (output wrEn, output addr, output wrData, input rdData);
    modport mem  (input wrEn, input addr, input wrData, output rdData);
endinterface : cdhp_mem_if

// ---- design/cdhp_ram.sv ----
`timescale 1ns/1ns
module cdhp_ram #(
    parameter int DEPTH = 80,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    cdhp_mem_if.mem  bus
);
    import cdhp_pkg::*;

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
        $error("cdhp_ram: DEPTH does not fit AW");
    end

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] cells;
        logic [DW-1:0]            rdData;
    } cdhp_ram_state_t;

    cdhp_ram_state_t r_reg, r_next;

    // ****************************************
    // Registered read, out of range reads zero
    // ****************************************
    always_comb begin
        r_next = r_reg;
        if (int'(bus.addr) < DEPTH) begin
            r_next.rdData = r_reg.cells[bus.addr];
            if (bus.wrEn)
                r_next.cells[bus.addr] = bus.wrData;
        end else begin
            r_next.rdData = '0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) r_reg <= '0;
        else r_reg <= r_next;
    end

    assign bus.rdData = r_reg.rdData;
endmodule : cdhp_ram

// ---- design/cdhp_map.sv ----
`timescale 1ns/1ns
module cdhp_map (
    input  wire logic [6:0] pos,
    input  wire logic       line,
    input  wire logic [6:0] shiftOff,
    input  wire logic       twoLine,
    output logic      [6:0] addr
);
    import cdhp_pkg::*;

    logic [7:0] sum;
    logic [7:0] lim;
    logic [6:0] idx;

    // ****************************************
    // Screen position to display RAM address
    // ****************************************
    always_comb begin
        lim = twoLine ? {1'b0, LINE_LEN} : 8'(ONE_LINE_LAST + 7'h01);
        sum = {1'b0, pos} + {1'b0, shiftOff};
        if (sum >= lim) sum = 8'(sum - lim); // [RQ22]
        if (sum >= lim) sum = 8'(sum - lim);
        idx = sum[6:0];
        // Two-line rows are not contiguous in RAM
        addr = (twoLine && line) ? 7'(LINE2_BASE + idx) : idx; // [RQ16] [RQ17]
    end
endmodule : cdhp_map

// ---- design/cdhp_top.sv ----
// Summary of operation
// (RQ1) Straps pick serial or parallel host bus
// (RQ2) Width bit picks four or eight lines
// (RQ3) Instruction latch and data holding register
// (RQ4) Host read refetches next RAM byte
// (RQ5) Host data write copies byte to RAM
// (RQ6) Instruction latch is never read back
// (RQ7) Select low: instruction write, status read
// (RQ8) Select high: data register write, read
// (RQ9) Busy flag high refuses further instructions
// (RQ10) Host polls busy flag before instructions
// (RQ11) Busy status readable on parallel only
// (RQ12) Eighty character codes addressed by counter
// (RQ13) Address counter holds current RAM address
// (RQ14) Each code picks one of 256 glyphs
// (RQ15) One-line display starts at first address
// (RQ16) Two-line rows not consecutive, forty each
// (RQ17) Sixteen by two maps 00-0F, 40-4F
// (RQ18) Display shift offsets every position one
// (RQ19) One-line shift moves addresses, not contents
// (RQ20) Counter steps after each data access
// (RQ21) Four-line mode: upper nibble first, DB7-4
// (RQ22) Shift wraps 00-27 and 40-67
`timescale 1ns/1ns
module cdhp_top #(
    parameter int LONG_OP_CYC = cdhp_pkg::LONG_OP_CYC
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       portTypeStrapHi,
    input  wire logic       portTypeStrapLo,
    input  wire logic       busEnable,
    input  wire logic       registerSelect,
    input  wire logic       readWrite,
    input  wire logic [7:0] dataIn,
    input  wire logic       serialCs_n,
    input  wire logic       serialClk,
    input  wire logic       serialDin,
    input  wire logic [6:0] scanPos,
    input  wire logic       scanLine,
    output logic      [7:0] dataOut,
    output logic            dataOe_n,
    output logic            busyFlag,
    output logic            displayOn,
    output logic      [6:0] scanAddr
);
    import cdhp_pkg::*;

    localparam int CW = $clog2(LONG_OP_CYC + 1);

    if (LONG_OP_CYC < SHORT_OP_CYC) begin : g_chk
        $error("cdhp_top: LONG_OP_CYC below SHORT_OP_CYC");
    end

    typedef struct packed {
        cdhp_state_t st;
        logic        strapDone;
        logic        portSerial;
        logic        eLast;
        logic        nibPhase;
        logic        oe;
        logic [3:0]  nibHi;
        logic [7:0]  rdLatch;
        logic [7:0]  dataOut;
        logic        sclkLast;
        logic [2:0]  serCnt;
        logic [7:0]  serShift;
        logic [7:0]  instr;
        logic [7:0]  dr;
        logic [6:0]  ac;
        logic        cgSel;
        logic        busWide;
        logic        twoLine;
        logic        incr;
        logic        autoShift;
        logic        dispOn;
        logic [6:0]  shiftOff;
        logic [6:0]  clrIdx;
        logic [CW-1:0] cnt;
        logic [6:0]  scanAddr;
    } cdhp_top_state_t;

    localparam cdhp_top_state_t RESET_STATE = '{
        st: ST_IDLE, busWide: RST_BUS_WIDE, twoLine: RST_TWO_LINE,
        incr: RST_INCR, default: '0};

    cdhp_top_state_t r_reg, r_next;

    cdhp_mem_if #(.AW(7), .DW(8)) ddBus ();
    cdhp_mem_if #(.AW(6), .DW(8)) cgBus ();

    logic       busy;
    logic       eRise;
    logic       eFall;
    logic       xferDone;
    logic       xferWrite;
    logic       xferRs;
    logic [7:0] xferByte;
    logic [7:0] rdByte;
    logic [7:0] memRd;
    logic [6:0] mapAddr;

    // ****************************************
    // Display RAM and glyph RAM
    // ****************************************
    cdhp_ram #(.DEPTH(DISPLAY_DATA_RAM_DEPTH), .AW(7), .DW(8)) u_display_data_ram (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .bus     (ddBus)
    );

    cdhp_ram #(.DEPTH(GLYPH_RAM_DEPTH), .AW(6), .DW(8)) u_glyph_ram (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .bus     (cgBus)
    );

    cdhp_map u_map (
        .pos      (scanPos),
        .line     (scanLine),
        .shiftOff (r_reg.shiftOff),
        .twoLine  (r_reg.twoLine),
        .addr     (mapAddr)
    );

    // Writes use the counter before it steps
    assign ddBus.addr   = (r_reg.st == ST_CLEAR) ? r_reg.clrIdx
                        : display_data_ram_index(r_reg.ac, r_reg.twoLine); // [RQ12] [RQ13]
    assign ddBus.wrEn   = (r_reg.st == ST_CLEAR)
                        || (r_reg.st == ST_WRITE && !r_reg.cgSel); // [RQ5]
    assign ddBus.wrData = (r_reg.st == ST_CLEAR) ? BLANK_CODE : r_reg.dr;
    assign cgBus.addr   = r_reg.ac[5:0];
    assign cgBus.wrEn   = (r_reg.st == ST_WRITE) && r_reg.cgSel; // [RQ5]
    assign cgBus.wrData = r_reg.dr;
    assign memRd        = r_reg.cgSel ? cgBus.rdData : ddBus.rdData;

    assign busy  = (r_reg.st != ST_IDLE); // [RQ9]
    assign eRise = busEnable && !r_reg.eLast;
    assign eFall = !busEnable && r_reg.eLast;

    // ****************************************
    // Host port and internal operations
    // ****************************************
    always_comb begin
        r_next    = r_reg;
        xferDone  = 1'b0;
        xferWrite = !readWrite;
        xferRs    = registerSelect;
        xferByte  = dataIn;
        // Status read never exposes the instruction latch
        rdByte    = registerSelect ? r_reg.dr
                  : {busy, r_reg.ac}; // [RQ6] [RQ7] [RQ8]
        // Straps caught once, after reset is released
        if (!r_reg.strapDone) begin
            r_next.strapDone  = 1'b1;
            r_next.portSerial = ({portTypeStrapHi, portTypeStrapLo}
                                 != STRAP_PARALLEL); // [RQ1]
        end else if (!r_reg.portSerial) begin
            r_next.eLast = busEnable;
            if (eRise && readWrite) begin
                r_next.oe = 1'b1;
                if (r_reg.busWide) begin
                    r_next.dataOut = rdByte;
                end else if (!r_reg.nibPhase) begin
                    // Latched so both nibbles come from one value
                    r_next.rdLatch = rdByte;
                    r_next.dataOut = {rdByte[7:4], 4'h0}; // [RQ21]
                end else begin
                    r_next.dataOut = {r_reg.rdLatch[3:0], 4'h0}; // [RQ21]
                end
            end
            if (eFall) begin
                r_next.oe = 1'b0;
                if (r_reg.busWide) begin // [RQ2]
                    xferDone = 1'b1;
                end else if (!r_reg.nibPhase) begin
                    r_next.nibHi    = dataIn[7:4];
                    r_next.nibPhase = 1'b1;
                end else begin
                    r_next.nibPhase = 1'b0;
                    xferDone        = 1'b1;
                    xferByte        = {r_reg.nibHi, dataIn[7:4]}; // [RQ21]
                end
            end
        end else begin
            // Serial path is write only; no status back
            r_next.sclkLast = serialClk;
            xferWrite       = 1'b1;
            xferByte        = {r_reg.serShift[6:0], serialDin};
            if (serialCs_n) begin
                r_next.serCnt = 3'h0;
            end else if (serialClk && !r_reg.sclkLast) begin
                r_next.serShift = xferByte;
                r_next.serCnt   = 3'(r_reg.serCnt + 3'h1);
                xferDone        = (r_reg.serCnt == 3'h7); // [RQ11]
            end
        end

        case (r_reg.st)
            ST_IDLE: begin
                if (xferDone && xferWrite && !xferRs) begin
                    r_next.instr = xferByte; // [RQ3] [RQ7]
                    r_next.st    = ST_WAIT;
                    r_next.cnt   = CW'(SHORT_OP_CYC - 1);
                    if (xferByte[CMD_DDADDR_BIT]) begin
                        r_next.ac    = xferByte[6:0];
                        r_next.cgSel = 1'b0;
                        r_next.st    = ST_FETCH;
                    end else if (xferByte[CMD_CGADDR_BIT]) begin
                        r_next.ac    = {1'b0, xferByte[5:0]};
                        r_next.cgSel = 1'b1;
                        r_next.st    = ST_FETCH;
                    end else if (xferByte[CMD_FUNC_BIT]) begin
                        r_next.busWide = xferByte[FUNC_DL_BIT]; // [RQ2]
                        r_next.twoLine = xferByte[FUNC_N_BIT];
                    end else if (xferByte[CMD_SHIFT_BIT]) begin
                        if (xferByte[SHIFT_SC_BIT])
                            r_next.shiftOff = shift_step(r_reg.shiftOff,
                                !xferByte[SHIFT_RL_BIT],
                                r_reg.twoLine); // [RQ18] [RQ19]
                        else
                            r_next.ac = ac_step(r_reg.ac,
                                xferByte[SHIFT_RL_BIT],
                                r_reg.twoLine, r_reg.cgSel);
                    end else if (xferByte[CMD_DISP_BIT]) begin
                        r_next.dispOn = xferByte[DISP_D_BIT];
                    end else if (xferByte[CMD_ENTRY_BIT]) begin
                        r_next.incr      = xferByte[ENTRY_ID_BIT];
                        r_next.autoShift = xferByte[ENTRY_S_BIT];
                    end else if (xferByte[CMD_HOME_BIT]) begin
                        r_next.ac       = 7'h00;
                        r_next.cgSel    = 1'b0;
                        r_next.shiftOff = 7'h00; // [RQ15]
                        r_next.cnt      = CW'(LONG_OP_CYC - 1);
                    end else if (xferByte[CMD_CLEAR_BIT]) begin
                        r_next.clrIdx = 7'h00;
                        r_next.st     = ST_CLEAR;
                    end else begin
                        r_next.st = ST_IDLE;
                    end
                end else if (xferDone && xferWrite) begin
                    r_next.dr = xferByte; // [RQ8]
                    r_next.st = ST_WRITE;
                end else if (xferDone && xferRs) begin
                    r_next.ac = ac_step(r_reg.ac, r_reg.incr,
                        r_reg.twoLine, r_reg.cgSel); // [RQ20]
                    r_next.st = ST_FETCH; // [RQ4]
                end
            end
            ST_WRITE: begin
                r_next.ac = ac_step(r_reg.ac, r_reg.incr,
                    r_reg.twoLine, r_reg.cgSel); // [RQ20]
                if (r_reg.autoShift && !r_reg.cgSel)
                    r_next.shiftOff = shift_step(r_reg.shiftOff,
                        r_reg.incr, r_reg.twoLine); // [RQ19]
                r_next.cnt = CW'(SHORT_OP_CYC - 1);
                r_next.st  = ST_WAIT;
            end
            ST_FETCH: r_next.st = ST_LOAD;
            ST_LOAD: begin
                r_next.dr  = memRd; // [RQ4]
                r_next.cnt = CW'(SHORT_OP_CYC - 1);
                r_next.st  = ST_WAIT;
            end
            ST_CLEAR: begin
                if (int'(r_reg.clrIdx) == DISPLAY_DATA_RAM_DEPTH - 1) begin
                    r_next.ac       = 7'h00;
                    r_next.cgSel    = 1'b0;
                    r_next.shiftOff = 7'h00;
                    r_next.incr     = 1'b1;
                    r_next.cnt      = CW'(LONG_OP_CYC - 1);
                    r_next.st       = ST_WAIT;
                end else begin
                    r_next.clrIdx = 7'(r_reg.clrIdx + 7'h01);
                end
            end
            ST_WAIT: begin
                if (r_reg.cnt == '0) r_next.st = ST_IDLE;
                else r_next.cnt = CW'(r_reg.cnt - 1'b1);
            end
            default: r_next.st = ST_IDLE;
        endcase
        // Code in RAM is the glyph index, 256 wide
        r_next.scanAddr = mapAddr; // [RQ14] [RQ17]
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) r_reg <= RESET_STATE;
        else r_reg <= r_next;
    end

    assign dataOut   = r_reg.dataOut;
    assign dataOe_n  = !r_reg.oe; // [RQ11]
    assign busyFlag  = busy;
    assign displayOn = r_reg.dispOn;
    assign scanAddr  = r_reg.scanAddr;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic parOn;
    assign parOn = r_reg.strapDone && !r_reg.portSerial;

    chk_busy_refuses: assert property ( // [RQ9]
        (busy && xferDone && xferWrite && !xferRs) |=> $stable(r_reg.instr))
        else $error("instruction taken while busy");
    chk_status_read: assert property ( // [RQ7]
        (parOn && eRise && readWrite && !registerSelect && r_reg.busWide)
        |=> dataOut == {$past(busy), $past(r_reg.ac)})
        else $error("status read wrong");
    chk_data_read: assert property ( // [RQ8]
        (parOn && eRise && readWrite && registerSelect && r_reg.busWide)
        |=> dataOut == $past(r_reg.dr))
        else $error("data read wrong");
    chk_write_commit: assert property ( // [RQ5]
        (!busy && xferDone && xferWrite && xferRs)
        |=> (ddBus.wrEn || cgBus.wrEn) && r_reg.dr == $past(xferByte))
        else $error("data write not committed");
    chk_read_refetch: assert property ( // [RQ4]
        (!busy && xferDone && !xferWrite && xferRs)
        |=> r_reg.st == ST_FETCH ##1 r_reg.st == ST_LOAD
        ##1 r_reg.dr == $past(memRd))
        else $error("refetch after read missing");
    chk_ac_step: assert property ( // [RQ20]
        (r_reg.st == ST_WRITE) |=> r_reg.ac == ac_step($past(r_reg.ac),
        $past(r_reg.incr), $past(r_reg.twoLine), $past(r_reg.cgSel)))
        else $error("address counter did not step");
    chk_serial_quiet: assert property ( // [RQ11]
        r_reg.portSerial |-> dataOe_n)
        else $error("serial mode drives data lines");
    chk_line_map: assert property ( // [RQ17]
        (r_reg.twoLine && r_reg.shiftOff == 7'h00 && scanPos < LINE_LEN)
        |=> scanAddr == ($past(scanLine) ? 7'(LINE2_BASE + $past(scanPos))
                                         : $past(scanPos)))
        else $error("unshifted two-line map wrong");
    chk_shift_wrap: assert property ( // [RQ22]
        (r_reg.twoLine && scanPos < LINE_LEN) |=> (scanAddr <= LINE1_LAST
        || (scanAddr >= LINE2_BASE && scanAddr <= LINE2_LAST)))
        else $error("shifted address out of line range");
    chk_nibble_pair: assert property ( // [RQ21]
        (parOn && !r_reg.busWide && eFall && !r_reg.nibPhase)
        |-> !xferDone ##1 r_reg.nibPhase)
        else $error("first nibble completed a transfer");

    cov_data_write: cover property (r_reg.st == ST_WRITE);
    cov_clear_done: cover property (r_reg.st == ST_CLEAR ##1 r_reg.st == ST_WAIT);
    cov_nibble_xfer: cover property (parOn && !r_reg.busWide && xferDone);
    cov_serial_xfer: cover property (r_reg.portSerial && xferDone);
endmodule : cdhp_top

// ---- tb/cdhp_host.sv ----
`timescale 1ns/1ns
module cdhp_host (
    input  wire logic       mclk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe_n,
    input  wire logic       busyFlag,
    output logic            busEnable,
    output logic            registerSelect,
    output logic            readWrite,
    output logic            serialCs_n,
    output logic            serialClk,
    output logic            serialDin,
    output logic      [7:0] dataIn
);
    logic nibMode = 1'b0;
    logic hung    = 1'b0;
    logic oeSeen  = 1'b1;
    initial begin
        busEnable      = 1'b0;
        registerSelect = 1'b0;
        readWrite      = 1'b0;
        dataIn         = 8'h00;
        serialCs_n     = 1'b1;
        serialClk      = 1'b0;
        serialDin      = 1'b0;
    end
    // Serial byte, MSB first, select held to the last bit
    task automatic shiftOut(input logic rs, input logic [7:0] d);
        @(posedge mclk);
        serialCs_n     <= 1'b0;
        registerSelect <= rs;
        for (int i = 7; i >= 0; i--) begin
            serialDin <= d[i];
            @(posedge mclk);
            serialClk <= 1'b1;
            @(posedge mclk);
            serialClk <= 1'b0;
        end
        @(posedge mclk);
        serialCs_n <= 1'b1;
    endtask : shiftOut
    // Lines held past the fall; fall is the taking edge
    task automatic strobe(input logic rs, rw, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge mclk);
        busEnable      <= 1'b1;
        registerSelect <= rs;
        readWrite      <= rw;
        dataIn         <= d;
        repeat (2) @(posedge mclk);
        q = dataOut;
        oeSeen = dataOe_n;
        busEnable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : strobe
    task automatic xfer(input logic rs, rw, input logic [7:0] d,
                        output logic [7:0] q);
        logic [7:0] hi;
        if (nibMode) begin // Upper nibble first
            strobe(rs, rw, {d[7:4], 4'h0}, hi);
            strobe(rs, rw, {d[3:0], 4'h0}, q);
            q = {hi[7:4], q[7:4]};
        end else begin
            strobe(rs, rw, d, q);
        end
    endtask : xfer
    // Status poll before the next instruction
    task automatic poll();
        logic [7:0] s;
        s = 8'hff;
        for (int i = 0; i < 400 && s[7] !== 1'b0; i++) begin
            xfer(1'b0, 1'b1, 8'h00, s);
        end
        if (s[7] !== 1'b0) hung = 1'b1;
    endtask : poll
    // Width change: phase of a status poll would be unknown
    task automatic waitIdle();
        for (int i = 0; i < 2000 && busyFlag !== 1'b0; i++) @(posedge mclk);
        if (busyFlag !== 1'b0) hung = 1'b1;
    endtask : waitIdle
endmodule : cdhp_host

// ---- tb/test_char_display_host_port.sv ----
`timescale 1ns/1ns
module test_char_display_host_port;
    logic       mclk, sys_rst, busEnable, registerSelect, readWrite;
    logic       dataOe_n, busyFlag, displayOn, scanLine;
    logic       strapLo, serialCs_n, serialClk, serialDin;
    logic [7:0] dataIn, dataOut, q;
    logic [6:0] scanPos, scanAddr;
    int         n_errors = 0;
    int         tests_run = 0;

    // Parallel straps first, serial after a second reset
    cdhp_top #(.LONG_OP_CYC(500)) cdhp_top_i (
        .mclk(mclk), .sys_rst(sys_rst),
        .portTypeStrapHi(1'b1), .portTypeStrapLo(strapLo),
        .busEnable(busEnable), .registerSelect(registerSelect),
        .readWrite(readWrite), .dataIn(dataIn),
        .serialCs_n(serialCs_n), .serialClk(serialClk),
        .serialDin(serialDin),
        .scanPos(scanPos), .scanLine(scanLine), .dataOut(dataOut),
        .dataOe_n(dataOe_n), .busyFlag(busyFlag),
        .displayOn(displayOn), .scanAddr(scanAddr));
    cdhp_host cdhp_host_i (
        .mclk(mclk), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .busyFlag(busyFlag), .busEnable(busEnable),
        .registerSelect(registerSelect), .readWrite(readWrite),
        .serialCs_n(serialCs_n), .serialClk(serialClk),
        .serialDin(serialDin), .dataIn(dataIn));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic put(input logic rs, input logic [7:0] d);
        cdhp_host_i.xfer(rs, 1'b0, d, q);
    endtask : put
    task automatic get(input logic rs, input logic [7:0] e, input string nm);
        cdhp_host_i.xfer(rs, 1'b1, 8'h00, q);
        chk(nm, e, q);
        chk("dataOe_n", 8'h00, {7'h00, cdhp_host_i.oeSeen});
    endtask : get
    task automatic ins(input logic [7:0] c);
        put(1'b0, c);
        cdhp_host_i.poll();
    endtask : ins
    task automatic scan(input logic [6:0] p, input logic l,
                        input logic [6:0] e);
        @(posedge mclk);
        scanPos  <= p;
        scanLine <= l;
        repeat (2) @(posedge mclk);
        chk("scanAddr", {1'b0, e}, {1'b0, scanAddr});
    endtask : scan
    task automatic wrap_up();
        if (cdhp_host_i.hung) n_errors++;
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // ****************************************
    // Watchdog, about three times the expected run
    // ****************************************
    initial begin
        #(40 * 30000);
        n_errors++;
        wrap_up();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_rst  = 1'b1;
        strapLo  = 1'b1;
        scanPos  = 7'h00;
        scanLine = 1'b0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        get(1'b0, 8'h00, "status");
        put(1'b0, 8'h85);
        cdhp_host_i.xfer(1'b0, 1'b1, 8'h00, q);
        chk("busyFlag", 8'h01, {7'h00, q[7]});
        cdhp_host_i.poll();
        get(1'b0, 8'h05, "status");
        put(1'b1, 8'h41);
        put(1'b0, 8'h90); // Dropped while busy
        cdhp_host_i.poll();
        get(1'b0, 8'h06, "status");
        put(1'b1, 8'h42);
        cdhp_host_i.poll();
        ins(8'h85);
        get(1'b1, 8'h41, "data");
        cdhp_host_i.poll();
        get(1'b1, 8'h42, "data");
        cdhp_host_i.poll();
        get(1'b0, 8'h07, "status");
        ins(8'h04);
        put(1'b1, 8'h43);
        cdhp_host_i.poll();
        get(1'b0, 8'h06, "status");
        ins(8'h0c);
        chk("displayOn", 8'h01, {7'h00, displayOn});
        scan(7'd9, 1'b0, 7'h09);
        ins(8'h38);
        scan(7'd15, 1'b0, 7'h0f);
        scan(7'd0, 1'b1, 7'h40);
        scan(7'd15, 1'b1, 7'h4f);
        ins(8'h18);
        scan(7'd0, 1'b0, 7'h01);
        scan(7'd15, 1'b1, 7'h50);
        ins(8'h1c);
        ins(8'h1c);
        scan(7'd0, 1'b0, 7'h27);
        scan(7'd0, 1'b1, 7'h67);
        scan(7'd1, 1'b1, 7'h40);
        put(1'b0, 8'h28);
        cdhp_host_i.waitIdle();
        cdhp_host_i.nibMode = 1'b1;
        ins(8'h83);
        get(1'b0, 8'h03, "status");
        put(1'b1, 8'h5a);
        cdhp_host_i.poll();
        ins(8'h83);
        get(1'b1, 8'h5a, "data");
        cdhp_host_i.poll();
        ins(8'h01);
        ins(8'h83);
        get(1'b1, 8'h20, "data");
        sys_rst <= 1'b1;
        strapLo <= 1'b0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        cdhp_host_i.shiftOut(1'b0, 8'h0c);
        chk("busyFlag", 8'h01, {7'h00, busyFlag});
        cdhp_host_i.waitIdle();
        chk("displayOn", 8'h01, {7'h00, displayOn});
        cdhp_host_i.strobe(1'b0, 1'b1, 8'h00, q);
        chk("dataOe_n", 8'h01, {7'h00, cdhp_host_i.oeSeen});
        wrap_up();
    end
endmodule : test_char_display_host_port
